// ---- hdl/vendor_cmd_pkg.sv ----
// Command codes, field positions and constants of the vendor command bank
package vendor_cmd_pkg;
    // Command codes
    localparam logic [7:0] CMD_ADDRESS = 8'hEF;
    localparam logic [7:0] CMD_CRC     = 8'hF0;
    localparam logic [7:0] CMD_FAULT   = 8'hF1;

    // Address field
    localparam int         ADDR_W        = 7;
    localparam logic [6:0] RSVD_ADDR_0   = 7'h0C;
    localparam logic [6:0] RSVD_ADDR_1   = 7'h28;
    localparam logic [6:0] RSVD_ADDR_2   = 7'h37;
    localparam logic [6:0] RSVD_ADDR_3   = 7'h61;
    localparam logic [6:0] ADDR_RESET    = 7'h00;

    // Checksum
    localparam logic [15:0] CRC_POLY  = 16'h8005;
    localparam logic [15:0] CRC_INIT  = 16'h0000;
    localparam logic [15:0] CRC_RESET = 16'h0000;

    // Fault injection fields
    localparam int          FI_FAULT_PERSIST = 15;
    localparam int          FI_OVERTEMP      = 14;
    localparam int          FI_OC_FAULT      = 12;
    localparam int          FI_IN_LOCKOUT    = 11;
    localparam int          FI_IN_OV_FAULT   = 10;
    localparam int          FI_OUT_UV_FAULT  = 9;
    localparam int          FI_OUT_OV_FAULT  = 8;
    localparam int          FI_WARN_PERSIST  = 7;
    localparam int          FI_OC_WARN       = 4;
    localparam int          FI_IN_UV_WARN    = 3;
    localparam int          FI_OUT_UV_WARN   = 1;
    localparam int          FI_OUT_OV_WARN   = 0;
    localparam logic [15:0] FI_FAULT_MASK    = 16'h7F00;
    localparam logic [15:0] FI_WARN_MASK     = 16'h007F;
    localparam logic [15:0] FI_RESET         = 16'h0000;
endpackage

// ---- hdl/settings_crc16.sv ----
// Bytewise CRC-16 engine over the settings stream
`timescale 1ns/1ns
`default_nettype none
module settings_crc16
    import vendor_cmd_pkg::*;
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        clk_en,
    // Byte stream
    input  wire logic        start,
    input  wire logic        byte_valid,
    input  wire logic [7:0]  byte_data,
    input  wire logic        byte_last,
    // Result
    output logic      [15:0] crc_out,
    output logic             crc_done
);
    logic [15:0] acc_q, acc_d, res_q, res_d, step;
    logic        done_q, done_d;

    always_comb begin
        step = acc_q;
        for (int i = 7; i >= 0; i--) begin
            if (step[15] ^ byte_data[i]) begin
                step = {step[14:0], 1'b0} ^ CRC_POLY;
            end else begin
                step = {step[14:0], 1'b0};
            end
        end
        acc_d  = acc_q;
        res_d  = res_q;
        done_d = 1'b0;
        if (start) begin
            acc_d = CRC_INIT;
        end else if (byte_valid) begin
            acc_d = step;
            if (byte_last) begin
                res_d  = step;
                done_d = 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            acc_q  <= CRC_INIT;
            res_q  <= CRC_RESET;
            done_q <= 1'b0;
        end else if (clk_en) begin
            acc_q  <= acc_d;
            res_q  <= res_d;
            done_q <= done_d;
        end
    end

    assign crc_out  = res_q;
    assign crc_done = done_q;
endmodule
`default_nettype wire

// ---- hdl/pmbus_addr_crc_fault_sim.sv ----
// Vendor command bank: bus address, settings checksum, fault injection
`timescale 1ns/1ns
`default_nettype none
module pmbus_addr_crc_fault_sim
    import vendor_cmd_pkg::*;
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        clk_en,
    // Command port from the transaction layer
    input  wire logic        cmd_valid,
    input  wire logic        cmd_write,
    input  wire logic        cmd_word,
    input  wire logic [7:0]  cmd_code,
    input  wire logic [15:0] cmd_wdata,
    output logic             rsp_valid,
    output logic             rsp_invalid,
    output logic      [15:0] rsp_rdata,
    // Address match
    input  wire logic [6:0]  addr_query,
    output logic             addr_hit,
    output logic      [6:0]  bus_address,
    // Boot and non-volatile events
    input  wire logic [6:0]  boot_addr,
    input  wire logic        nvm_store_done,
    input  wire logic        nvm_restore_done,
    output logic             crc_request,
    input  wire logic        nvm_byte_valid,
    input  wire logic [7:0]  nvm_byte,
    input  wire logic        nvm_byte_last,
    // Protection side
    input  wire logic        conv_enabled,
    input  wire logic        fault_resp_done,
    output logic             force_overtemp_fault,
    output logic             force_overcurrent_fault,
    output logic             force_input_lockout,
    output logic             force_input_overvolt_fault,
    output logic             force_output_undervolt_fault,
    output logic             force_output_overvolt_fault,
    output logic             force_overcurrent_warning,
    output logic             force_input_undervolt_warning,
    output logic             force_output_undervolt_warning,
    output logic             force_output_overvolt_warning
);
    logic [6:0]  addr_q, addr_d;
    logic [15:0] crc_q, crc_d;
    logic [15:0] fi_q, fi_d;
    logic        boot_q, boot_d;
    logic        req_q, req_d;
    logic        rv_q, rv_d, ri_q, ri_d;
    logic [15:0] rd_q, rd_d;
    logic [15:0] crc_val;
    logic        crc_done;
    logic        addr_rsvd, wr_addr_ok, wr_fi_ok;

    settings_crc16 u_crc (
        .clk        (clk),
        .rst_n      (rst_n),
        .clk_en     (clk_en),
        .start      (req_q),
        .byte_valid (nvm_byte_valid),
        .byte_data  (nvm_byte),
        .byte_last  (nvm_byte_last),
        .crc_out    (crc_val),
        .crc_done   (crc_done)
    );

    assign addr_rsvd  = (cmd_wdata[6:0] == RSVD_ADDR_0) || (cmd_wdata[6:0] == RSVD_ADDR_1)
                     || (cmd_wdata[6:0] == RSVD_ADDR_2) || (cmd_wdata[6:0] == RSVD_ADDR_3);
    assign wr_addr_ok = cmd_valid && cmd_write && !cmd_word && (cmd_code == CMD_ADDRESS)
                     && !addr_rsvd;
    assign wr_fi_ok   = cmd_valid && cmd_write && cmd_word && (cmd_code == CMD_FAULT);

    // Address, boot capture and checksum
    always_comb begin
        addr_d = addr_q;
        boot_d = 1'b0;
        req_d  = nvm_store_done || nvm_restore_done;
        crc_d  = crc_q;
        if (boot_q) begin
            addr_d = boot_addr;
            req_d  = 1'b1;
        end else if (wr_addr_ok) begin
            addr_d = cmd_wdata[6:0];
        end
        if (crc_done) begin
            crc_d = crc_val;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            addr_q <= ADDR_RESET;
            boot_q <= 1'b1;
            req_q  <= 1'b0;
            crc_q  <= CRC_RESET;
        end else if (clk_en) begin
            addr_q <= addr_d;
            boot_q <= boot_d;
            req_q  <= req_d;
            crc_q  <= crc_d;
        end
    end

    assign addr_hit    = !boot_q && (addr_query == addr_q);
    assign bus_address = addr_q;
    assign crc_request = req_q;

    // Fault injection register
    always_comb begin
        fi_d = fi_q;
        if (wr_fi_ok) begin
            fi_d = cmd_wdata;
        end else if (fault_resp_done) begin
            if (!fi_q[FI_FAULT_PERSIST]) begin
                fi_d = fi_d & ~FI_FAULT_MASK;
            end
            if (!fi_q[FI_WARN_PERSIST]) begin
                fi_d = fi_d & ~(FI_WARN_MASK & ~(16'h0001 << FI_WARN_PERSIST));
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            fi_q <= FI_RESET;
        end else if (clk_en) begin
            fi_q <= fi_d;
        end
    end

    // Forced detector outputs
    assign force_overtemp_fault           = fi_q[FI_OVERTEMP]     && conv_enabled;
    assign force_overcurrent_fault        = fi_q[FI_OC_FAULT]     && conv_enabled;
    assign force_input_lockout            = fi_q[FI_IN_LOCKOUT];
    assign force_input_overvolt_fault     = fi_q[FI_IN_OV_FAULT]  && conv_enabled;
    assign force_output_undervolt_fault   = fi_q[FI_OUT_UV_FAULT] && conv_enabled;
    assign force_output_overvolt_fault    = fi_q[FI_OUT_OV_FAULT];
    assign force_overcurrent_warning      = fi_q[FI_OC_WARN]      && conv_enabled;
    assign force_input_undervolt_warning  = fi_q[FI_IN_UV_WARN]   && conv_enabled;
    assign force_output_undervolt_warning = fi_q[FI_OUT_UV_WARN]  && conv_enabled;
    assign force_output_overvolt_warning  = fi_q[FI_OUT_OV_WARN]  && conv_enabled;

    // Command responses
    always_comb begin
        rv_d = cmd_valid;
        ri_d = 1'b0;
        rd_d = 16'h0000;
        if (cmd_valid) begin
            unique case (cmd_code)
                CMD_ADDRESS: begin
                    ri_d = cmd_word || (cmd_write && addr_rsvd);
                    rd_d = (cmd_write || cmd_word) ? 16'h0000 : {9'h000, addr_q};
                end
                CMD_CRC: begin
                    ri_d = cmd_write || !cmd_word;
                    rd_d = ri_d ? 16'h0000 : crc_q;
                end
                CMD_FAULT: begin
                    ri_d = !cmd_word;
                    rd_d = (cmd_write || !cmd_word) ? 16'h0000 : fi_q;
                end
                default: begin
                    ri_d = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rv_q <= 1'b0;
            ri_q <= 1'b0;
            rd_q <= 16'h0000;
        end else if (clk_en) begin
            rv_q <= rv_d;
            ri_q <= ri_d;
            rd_q <= rd_d;
        end
    end

    assign rsp_valid   = rv_q;
    assign rsp_invalid = ri_q;
    assign rsp_rdata   = rd_q;

    // Checks
    sequence s_addr_write;
        clk_en && wr_addr_ok && !boot_q;
    endsequence

    sequence s_fi_write;
        clk_en && wr_fi_ok;
    endsequence

    a_addr_takes_new: assert property (@(posedge clk) disable iff (!rst_n)
        s_addr_write |=> bus_address == $past(cmd_wdata[6:0]))
        else $error("address not taken from write");

    a_addr_old_dead: assert property (@(posedge clk) disable iff (!rst_n)
        (s_addr_write ##0 (cmd_wdata[6:0] != addr_q)) |=>
        (addr_query == $past(addr_q)) |-> !addr_hit)
        else $error("old address still hit");

    a_addr_rsvd_kept: assert property (@(posedge clk) disable iff (!rst_n)
        (clk_en && !boot_q && cmd_valid && cmd_write && !cmd_word
         && cmd_code == CMD_ADDRESS && addr_rsvd) |=> $stable(bus_address) && rsp_invalid)
        else $error("reserved address accepted");

    a_addr_read_back: assert property (@(posedge clk) disable iff (!rst_n)
        (clk_en && cmd_valid && !cmd_write && !cmd_word && cmd_code == CMD_ADDRESS)
        |=> rsp_rdata[15:7] == 9'h000 && rsp_rdata[6:0] == $past(addr_q))
        else $error("address read back wrong");

    a_crc_boot_req: assert property (@(posedge clk) disable iff (!rst_n)
        (clk_en && boot_q) |=> crc_request)
        else $error("no checksum at boot");

    a_crc_store_req: assert property (@(posedge clk) disable iff (!rst_n)
        (clk_en && (nvm_store_done || nvm_restore_done)) |=> crc_request)
        else $error("no checksum after store or restore");

    a_crc_no_write: assert property (@(posedge clk) disable iff (!rst_n)
        (clk_en && cmd_valid && cmd_write && cmd_code == CMD_CRC && !crc_done)
        |=> rsp_invalid && $stable(crc_q))
        else $error("checksum write not refused");

    a_fault_one_shot: assert property (@(posedge clk) disable iff (!rst_n)
        (clk_en && !wr_fi_ok && fault_resp_done && !fi_q[FI_FAULT_PERSIST])
        |=> (fi_q & FI_FAULT_MASK) == 16'h0000)
        else $error("non-persistent fault kept");

    a_fault_persist: assert property (@(posedge clk) disable iff (!rst_n)
        (clk_en && !wr_fi_ok && fi_q[FI_FAULT_PERSIST]) |=> $stable(fi_q[14:8]))
        else $error("persistent fault lost");

    a_warn_one_shot: assert property (@(posedge clk) disable iff (!rst_n)
        (clk_en && !wr_fi_ok && fault_resp_done && !fi_q[FI_WARN_PERSIST])
        |=> fi_q[6:0] == 7'h00)
        else $error("non-persistent warning kept");

    a_conv_off_gate: assert property (@(posedge clk) disable iff (!rst_n)
        !conv_enabled |-> !force_overtemp_fault && !force_input_overvolt_fault
        && !force_overcurrent_fault && !force_output_undervolt_fault
        && force_input_lockout == fi_q[FI_IN_LOCKOUT])
        else $error("simulation active while conversion off");

    a_fi_write_load: assert property (@(posedge clk) disable iff (!rst_n)
        s_fi_write ##1 conv_enabled |->
        force_overtemp_fault == $past(cmd_wdata[FI_OVERTEMP])
        && force_input_lockout == $past(cmd_wdata[FI_IN_LOCKOUT]))
        else $error("injection write not applied");
endmodule
`default_nettype wire

// ---- tb/settings_store_model.sv ----
// Settings store model streaming checksum bytes on request
`timescale 1ns/1ns
`default_nettype none
module settings_store_model #(
    parameter int N_BYTES = 3,
    parameter int GAP     = 1
) (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst_n,
    // Stream control
    input  wire logic       crc_request,
    input  wire logic [7:0] salt,
    // Byte stream
    output logic            nvm_byte_valid,
    output logic      [7:0] nvm_byte,
    output logic            nvm_byte_last
);
    int i;
    initial begin
        nvm_byte_valid = 1'b0;
        nvm_byte       = 8'h00;
        nvm_byte_last  = 1'b0;
        forever begin
            @(posedge clk);
            // Answer each request seen while no stream is running with the whole settings image
            if (rst_n === 1'b1 && crc_request === 1'b1) begin
                for (i = 0; i < N_BYTES; i++) begin
                    @(negedge clk);
                    nvm_byte_valid = 1'b1;
                    nvm_byte       = (8'h5A + 8'(8'h11 * i)) ^ salt;
                    nvm_byte_last  = (i == N_BYTES - 1);
                    @(negedge clk);
                    nvm_byte_valid = 1'b0;
                    nvm_byte       = ~nvm_byte;
                    nvm_byte_last  = 1'b0;
                    repeat (GAP) @(negedge clk);
                end
            end
        end
    end
endmodule
`default_nettype wire

// ---- tb/tb_pmbus_addr_crc_fault_sim.sv ----
// Testbench of the vendor command bank
`timescale 1ns/1ns
`default_nettype none
module tb_pmbus_addr_crc_fault_sim;
    import vendor_cmd_pkg::*;
    logic clk, rst_n, clk_en, cmd_valid, cmd_write, cmd_word, rsp_valid, rsp_invalid;
    logic [7:0] cmd_code, salt, nvm_byte;
    logic [15:0] cmd_wdata, rsp_rdata;
    logic [6:0] addr_query, bus_address;
    logic addr_hit, nvm_store_done, nvm_restore_done, crc_request;
    logic nvm_byte_valid, nvm_byte_last, conv_enabled, fault_resp_done;
    logic [9:0] fv;
    int n_fail, comparisons;

    pmbus_addr_crc_fault_sim dut (.clk(clk), .rst_n(rst_n), .clk_en(clk_en),
        .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_word(cmd_word),
        .cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid),
        .rsp_invalid(rsp_invalid), .rsp_rdata(rsp_rdata), .addr_query(addr_query),
        .addr_hit(addr_hit), .bus_address(bus_address), .boot_addr(7'h1A),
        .nvm_store_done(nvm_store_done), .nvm_restore_done(nvm_restore_done),
        .crc_request(crc_request), .nvm_byte_valid(nvm_byte_valid),
        .nvm_byte(nvm_byte), .nvm_byte_last(nvm_byte_last),
        .conv_enabled(conv_enabled), .fault_resp_done(fault_resp_done),
        .force_overtemp_fault(fv[9]), .force_overcurrent_fault(fv[8]),
        .force_input_lockout(fv[7]), .force_input_overvolt_fault(fv[6]),
        .force_output_undervolt_fault(fv[5]), .force_output_overvolt_fault(fv[4]),
        .force_overcurrent_warning(fv[3]), .force_input_undervolt_warning(fv[2]),
        .force_output_undervolt_warning(fv[1]), .force_output_overvolt_warning(fv[0]));

    settings_store_model #(.N_BYTES(3), .GAP(1)) store (.clk(clk), .rst_n(rst_n),
        .crc_request(crc_request), .salt(salt), .nvm_byte_valid(nvm_byte_valid),
        .nvm_byte(nvm_byte), .nvm_byte_last(nvm_byte_last));

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // One command, answer checked one cycle later
    task automatic cmd(input logic w, input logic wd, input logic [7:0] code,
                       input logic [15:0] d, input logic inv, input logic [15:0] rd);
        @(negedge clk);
        cmd_valid = 1'b1;
        cmd_write = w;
        cmd_word  = wd;
        cmd_code  = code;
        cmd_wdata = d;
        @(negedge clk);
        cmd_valid = 1'b0;
        cmd_wdata = ~d;
        chk("rsp_valid", 16'(rsp_valid), 16'h0001);
        chk("rsp_invalid", 16'(rsp_invalid), 16'(inv));
        chk("rsp_rdata", rsp_rdata, rd);
    endtask

    function automatic logic [15:0] exp_crc(input logic [7:0] s);
        logic [15:0] c;
        logic [7:0] b;
        logic fb;
        c = 16'h0000;
        for (int i = 0; i < 3; i++) begin
            b = (8'h5A + 8'(8'h11 * i)) ^ s;
            for (int k = 7; k >= 0; k--) begin
                fb = c[15] ^ b[k];
                c = {c[14:0], 1'b0};
                if (fb) c = c ^ 16'h8005;
            end
        end
        return c;
    endfunction

    function automatic logic [9:0] fmap(input logic [15:0] w);
        return {w[14], w[12], w[11], w[10], w[9], w[8], w[4], w[3], w[1], w[0]};
    endfunction

    task automatic pulse_resp();
        @(negedge clk);
        fault_resp_done = 1'b1;
        @(negedge clk);
        fault_resp_done = 1'b0;
    endtask

    task automatic t_boot();
        chk("boot address", 16'(bus_address), 16'h001A);
        chk("boot hit", 16'(addr_hit), 16'h0001);
        chk("force idle", 16'(fv), 16'h0000);
        cmd(1'b0, 1'b1, CMD_FAULT, 16'h0000, 1'b0, 16'h0000);
        cmd(1'b0, 1'b1, CMD_CRC, 16'h0000, 1'b0, exp_crc(8'h00));
        $display("test boot done");
    endtask

    task automatic t_address();
        logic [6:0] rsv [4];
        rsv = '{RSVD_ADDR_0, RSVD_ADDR_1, RSVD_ADDR_2, RSVD_ADDR_3};
        cmd(1'b1, 1'b0, CMD_ADDRESS, 16'h00A2, 1'b0, 16'h0000);
        addr_query = 7'h1A;
        #1 chk("old address hit", 16'(addr_hit), 16'h0000);
        @(negedge clk);
        addr_query = 7'h22;
        #1 chk("new address hit", 16'(addr_hit), 16'h0001);
        cmd(1'b0, 1'b0, CMD_ADDRESS, 16'h0000, 1'b0, 16'h0022);
        foreach (rsv[j]) cmd(1'b1, 1'b0, CMD_ADDRESS, 16'(rsv[j]), 1'b1, 16'h0000);
        cmd(1'b1, 1'b1, CMD_ADDRESS, 16'h0033, 1'b1, 16'h0000);
        chk("address kept", 16'(bus_address), 16'h0022);
        cmd(1'b1, 1'b0, 8'hEE, 16'h0011, 1'b1, 16'h0000);
        $display("test address done");
    endtask

    task automatic t_crc();
        cmd(1'b1, 1'b1, CMD_CRC, 16'h1234, 1'b1, 16'h0000);
        cmd(1'b0, 1'b0, CMD_CRC, 16'h0000, 1'b1, 16'h0000);
        salt = 8'h3C;
        @(negedge clk);
        nvm_store_done = 1'b1;
        @(negedge clk);
        nvm_store_done = 1'b0;
        repeat (12) @(negedge clk);
        cmd(1'b0, 1'b1, CMD_CRC, 16'h0000, 1'b0, exp_crc(8'h3C));
        salt = 8'hC1;
        @(negedge clk);
        nvm_restore_done = 1'b1;
        @(negedge clk);
        nvm_restore_done = 1'b0;
        repeat (12) @(negedge clk);
        cmd(1'b0, 1'b1, CMD_CRC, 16'h0000, 1'b0, exp_crc(8'hC1));
        $display("test checksum done");
    endtask

    task automatic t_fault();
        logic [15:0] bits [11];
        bits = '{16'h4000, 16'h2000, 16'h1000, 16'h0800, 16'h0400, 16'h0200,
                 16'h0100, 16'h0010, 16'h0008, 16'h0002, 16'h0001};
        conv_enabled = 1'b1;
        foreach (bits[j]) begin
            cmd(1'b1, 1'b1, CMD_FAULT, bits[j], 1'b0, 16'h0000);
            chk("force one", 16'(fv), 16'(fmap(bits[j])));
        end
        cmd(1'b1, 1'b1, CMD_FAULT, 16'h5F1B, 1'b0, 16'h0000);
        chk("force many", 16'(fv), 16'h03FF);
        cmd(1'b0, 1'b1, CMD_FAULT, 16'h0000, 1'b0, 16'h5F1B);
        cmd(1'b1, 1'b0, CMD_FAULT, 16'h0001, 1'b1, 16'h0000);
        pulse_resp();
        chk("one response clears", 16'(fv), 16'h0000);
        cmd(1'b1, 1'b1, CMD_FAULT, 16'hC092, 1'b0, 16'h0000);
        pulse_resp();
        chk("persist kept", 16'(fv), 16'(fmap(16'hC092)));
        cmd(1'b0, 1'b1, CMD_FAULT, 16'h0000, 1'b0, 16'hC092);
        cmd(1'b1, 1'b1, CMD_FAULT, 16'h8112, 1'b0, 16'h0000);
        pulse_resp();
        chk("warning cleared", 16'(fv), 16'h0010);
        cmd(1'b1, 1'b1, CMD_FAULT, 16'h0492, 1'b0, 16'h0000);
        pulse_resp();
        chk("fault cleared", 16'(fv), 16'h000A);
        conv_enabled = 1'b0;
        cmd(1'b1, 1'b1, CMD_FAULT, 16'hDF9B, 1'b0, 16'h0000);
        chk("conversion off", 16'(fv), 16'h0090);
        conv_enabled = 1'b1;
        #1 chk("conversion on", 16'(fv), 16'h03FF);
        $display("test fault injection done");
    endtask

    task automatic t_freeze();
        @(negedge clk);
        clk_en    = 1'b0;
        cmd_valid = 1'b1;
        cmd_write = 1'b1;
        cmd_word  = 1'b1;
        cmd_code  = CMD_FAULT;
        cmd_wdata = 16'h0000;
        repeat (2) @(negedge clk);
        chk("frozen force", 16'(fv), 16'h03FF);
        chk("frozen rsp_valid", 16'(rsp_valid), 16'h0000);
        cmd_valid = 1'b0;
        clk_en    = 1'b1;
        @(negedge clk);
        chk("thawed force", 16'(fv), 16'h03FF);
        $display("test clock enable done");
    endtask

    task automatic t_reset();
        @(negedge clk);
        rst_n = 1'b0;
        repeat (2) @(negedge clk);
        rst_n = 1'b1;
        chk("reset force", 16'(fv), 16'h0000);
        repeat (20) @(negedge clk);
        chk("reboot address", 16'(bus_address), 16'h001A);
        cmd(1'b0, 1'b1, CMD_FAULT, 16'h0000, 1'b0, 16'h0000);
        cmd(1'b0, 1'b1, CMD_CRC, 16'h0000, 1'b0, exp_crc(8'hC1));
        $display("test mid-run reset done");
    endtask

    initial begin
        n_fail = 0;
        comparisons = 0;
        #100000;
        n_fail++;
        conclude();
    end

    initial begin
        rst_n = 1'b0;
        {cmd_valid, cmd_write, cmd_word, nvm_store_done, nvm_restore_done} = 5'h00;
        {conv_enabled, fault_resp_done} = 2'h0;
        clk_en = 1'b1;
        cmd_code = 8'h00;
        cmd_wdata = 16'h0000;
        salt = 8'h00;
        addr_query = 7'h1A;
        repeat (8) @(negedge clk);
        rst_n = 1'b1;
        repeat (20) @(negedge clk);
        t_boot();
        t_address();
        t_crc();
        t_fault();
        t_freeze();
        t_reset();
        conclude();
    end
endmodule
`default_nettype wire
